// ==== ism_consts.svh ====
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
// Device clock rate and target serial clock rate, in kHz
`define ISM_CLK_KHZ 10000
`define ISM_SCL_KHZ 380

// ****************************************
// Byte framing
// ****************************************
// Bit index of the acknowledge slot and of the last data bit
`define ISM_ACK_IDX 4'h8
`define ISM_LAST_BIT_IDX 4'h7
`define ISM_FIRST_BIT_IDX 4'h0
// Direction flag in bit 0 of the address byte
`define ISM_RD_FLAG 1'h1
`define ISM_WR_FLAG 1'h0
// Receive shifter preset while the slave drives data
`define ISM_IDLE_BYTE 8'hff
// Byte count that marks the final byte
`define ISM_ONE_BYTE 8'h01
`define ISM_ZERO_BYTE 8'h00
// Low drive level on an open-drain pin
`define ISM_DRIVE_LOW 1'h0

`endif

// ==== ism_pkg.sv ====
`default_nettype none

// ****************************************
// Types of the serial bus master
// ****************************************
package ism_pkg;

  // Bus sequencer states
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_START  = 4'h1,
    S_LOW    = 4'h2,
    S_HIGH   = 4'h3,
    S_STOP_A = 4'h4,
    S_STOP_B = 4'h5,
    S_STOP_C = 4'h6,
    S_RST_A  = 4'h7,
    S_RST_B  = 4'h8
  } ism_state_t;

  // Which byte of the transaction is on the wire
  typedef enum logic [2:0] {
    P_ADDR_W = 3'h0,
    P_REG    = 3'h1,
    P_WDATA  = 3'h2,
    P_ADDR_R = 3'h3,
    P_RDATA  = 3'h4
  } ism_phase_t;

endpackage

`default_nettype wire

// ==== ism_sync.sv ====
`default_nettype none

// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module ism_sync #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // One pair of flops per bit, idling high like the bus
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta_reg[g] <= 1'h1;
        sync_reg[g] <= 1'h1;
      end else begin
        meta_reg[g] <= i_async[g];
        sync_reg[g] <= meta_reg[g];
      end
    end
  end

  assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ==== ism_master.sv ====
// Behaviour
// [RQ1] This block alone drives the serial clock in every transaction.
// [RQ2] Single master only; no arbitration or arbitration-loss handling.
// [RQ3] Slaves never start a transfer; the master starts and controls all.
// [RQ4] Data changes with clock high only to form start or stop.
// [RQ5] Transmitter holds data stable while the clock is high.
// [RQ6] Both lines open-drain: pull low or release to the pull-up.
// [RQ7] Bytes go out as 8 bits, MSB first, clock pulsed high then low.
// [RQ8] A ninth clock after each byte carries the receiver's acknowledge.
// [RQ9] Receiver acknowledges low when accepting, leaves high when it cannot.
// [RQ10] A high acknowledge makes the master issue a stop.
// [RQ11] Serial clock runs at roughly 380 kHz.
// [RQ12] Address byte: 7-bit address in bits 7..1, direction in bit 0.
// [RQ13] Slaves not addressed ignore the transaction until the next start.
// [RQ14] Write: start, address+write, register, data bytes, stop.
// [RQ15] Slaves advance their register pointer after each data byte.
// [RQ16] Read: start, addr+write, register, restart, addr+read, bytes, stop.
// [RQ17] Clock stretching unsupported; clock timing proceeds regardless.
// [RQ18] Master acknowledges read bytes low except the last before stop.
// [RQ19] Both lines are released and idle high between transactions.
`include "ism_consts.svh"
`default_nettype none

module ism_master
  import ism_pkg::*;
#(
  parameter int CLK_KHZ = `ISM_CLK_KHZ,
  parameter int SCL_KHZ = `ISM_SCL_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic i_rd,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_regnum,
  input wire logic [7:0] i_len,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_take,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_scl_stretch,
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n
);

  // ****************************************
  // Timing constants
  // ****************************************
  localparam int HALF_I = CLK_KHZ / (2 * SCL_KHZ);
  localparam int HALF_M1_I = HALF_I - 1;
  localparam int STOP_WIN = 2 * HALF_I;
  localparam logic [7:0] HALF_M1 = 8'(HALF_M1_I);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;

  ism_sync #(.W(2)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_scl_in, i_sda_in}),
    .o_sync(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ****************************************
  // Line decode
  // ****************************************
  // Release SDA (1) or pull it low (0) for a given sequencer position
  function automatic logic sda_release(ism_state_t st, ism_phase_t ph,
                                       logic [3:0] bc, logic [7:0] sh, logic last);
    logic rel;
    rel = 1'h1;
    case (st)
      S_START, S_STOP_A, S_STOP_B: rel = `ISM_DRIVE_LOW;
      S_LOW, S_HIGH: rel = (bc == `ISM_ACK_IDX) ? ((ph == P_RDATA) ? last : 1'h1) // RQ8 RQ18
                                                : ((ph == P_RDATA) ? 1'h1 : sh[7]); // RQ7
      default: rel = 1'h1; // RQ19
    endcase
    return rel;
  endfunction

  // Release SCL except in the low halves that this block times
  function automatic logic scl_release(ism_state_t st);
    logic rel;
    case (st)
      S_LOW, S_STOP_A, S_RST_A: rel = `ISM_DRIVE_LOW;
      default: rel = 1'h1;
    endcase
    return rel;
  endfunction

  // ****************************************
  // Sequencer state
  // ****************************************
  ism_state_t state_reg, state_next;
  ism_phase_t phase_reg, phase_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] left_reg, left_next;
  logic [6:0] addr_reg, addr_next;
  logic [7:0] regn_reg, regn_next;
  logic [7:0] rxd_reg, rxd_next;
  logic rd_reg, rd_next, nack_reg, nack_next, done_reg, done_next;
  logic take_reg, take_next, rxv_reg, rxv_next, stretch_reg, stretch_next;
  logic busy_reg, busy_next, scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;
  logic tick, last;

  assign tick = (cnt_reg == `ISM_ZERO_BYTE);
  assign last = (left_reg == `ISM_ONE_BYTE);

  // Next-state logic of the whole bus sequence
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = tick ? HALF_M1 : cnt_reg - 8'h01; // RQ11
    bit_next = bit_reg;
    shift_next = shift_reg;
    left_next = left_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    regn_next = regn_reg;
    nack_next = nack_reg;
    stretch_next = stretch_reg;
    rxd_next = rxd_reg;
    done_next = 1'h0;
    take_next = 1'h0;
    rxv_next = 1'h0;
    case (state_reg)
      S_IDLE: begin
        cnt_next = HALF_M1;
        if (i_go) begin // RQ3
          state_next = S_START; // RQ4
          phase_next = P_ADDR_W;
          bit_next = `ISM_FIRST_BIT_IDX;
          shift_next = {i_addr, `ISM_WR_FLAG}; // RQ12 RQ14 RQ16
          rd_next = i_rd;
          addr_next = i_addr;
          regn_next = i_regnum;
          left_next = (i_len == `ISM_ZERO_BYTE) ? `ISM_ONE_BYTE : i_len;
          nack_next = 1'h0;
          stretch_next = 1'h0;
        end
      end
      S_START: if (tick) state_next = S_LOW;
      S_LOW: if (tick) state_next = S_HIGH; // RQ7
      S_HIGH: begin
        // Clock proceeds even if a slave holds SCL low; only flagged
        if (tick && !scl_s) stretch_next = 1'h1; // RQ17
        if (tick && bit_reg != `ISM_ACK_IDX) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
          state_next = S_LOW;
          if (phase_reg == P_RDATA && bit_reg == `ISM_LAST_BIT_IDX) begin
            rxd_next = {shift_reg[6:0], sda_s};
            rxv_next = 1'h1;
          end
        end else if (tick) begin
          bit_next = `ISM_FIRST_BIT_IDX;
          state_next = S_LOW;
          if (phase_reg != P_RDATA && sda_s) begin
            nack_next = 1'h1; // RQ10
            state_next = S_STOP_A;
          end else begin
            case (phase_reg)
              P_ADDR_W: begin
                phase_next = P_REG;
                shift_next = regn_reg;
              end
              P_REG: begin
                if (rd_reg) begin
                  phase_next = P_ADDR_R; // RQ16
                  shift_next = {addr_reg, `ISM_RD_FLAG}; // RQ12
                  state_next = S_RST_A;
                end else begin
                  phase_next = P_WDATA; // RQ14
                  shift_next = i_tx_data;
                  take_next = 1'h1;
                end
              end
              P_WDATA: begin
                if (last) begin
                  state_next = S_STOP_A;
                end else begin
                  left_next = left_reg - 8'h01;
                  shift_next = i_tx_data;
                  take_next = 1'h1;
                end
              end
              P_ADDR_R: begin
                phase_next = P_RDATA;
                shift_next = `ISM_IDLE_BYTE;
              end
              default: begin
                // Final read byte was left unacknowledged, so stop
                if (last) state_next = S_STOP_A; // RQ18
                else left_next = left_reg - 8'h01;
              end
            endcase
          end
        end
      end
      S_RST_A: if (tick) state_next = S_RST_B;
      S_RST_B: if (tick) state_next = S_START;
      S_STOP_A: if (tick) state_next = S_STOP_B;
      S_STOP_B: if (tick) state_next = S_STOP_C; // RQ4
      S_STOP_C: begin
        if (tick) begin
          state_next = S_IDLE; // RQ19
          done_next = 1'h1;
        end
      end
      default: state_next = S_IDLE;
    endcase
    busy_next = (state_next != S_IDLE);
    scl_oe_n_next = scl_release(state_next); // RQ1 RQ2 RQ6
    sda_oe_n_next = sda_release(state_next, phase_next, bit_next, shift_next,
                                left_next == `ISM_ONE_BYTE); // RQ5 RQ6
  end

  // Registers of the sequencer and of the pin drivers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      phase_reg <= P_ADDR_W;
      {cnt_reg, bit_reg, rd_reg, addr_reg, regn_reg, rxd_reg} <= '0;
      {shift_reg, left_reg} <= {8'hff, 8'h01};
      {nack_reg, done_reg, take_reg, rxv_reg, stretch_reg, busy_reg} <= '0;
      {scl_oe_n_reg, sda_oe_n_reg} <= 2'h3;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      {cnt_reg, bit_reg, shift_reg, left_reg} <= {cnt_next, bit_next, shift_next, left_next};
      {rd_reg, addr_reg, regn_reg, rxd_reg} <= {rd_next, addr_next, regn_next, rxd_next};
      {nack_reg, done_reg, take_reg, rxv_reg} <= {nack_next, done_next, take_next, rxv_next};
      {stretch_reg, busy_reg} <= {stretch_next, busy_next};
      {scl_oe_n_reg, sda_oe_n_reg} <= {scl_oe_n_next, sda_oe_n_next};
    end
  end

  // Output drive straight from flops; pins only ever pull low
  assign o_scl_out = `ISM_DRIVE_LOW;
  assign o_sda_out = `ISM_DRIVE_LOW;
  assign o_scl_oe_n = scl_oe_n_reg;
  assign o_sda_oe_n = sda_oe_n_reg;
  assign o_tx_take = take_reg;
  assign o_rx_data = rxd_reg;
  assign o_rx_valid = rxv_reg;
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_nack = nack_reg;
  assign o_scl_stretch = stretch_reg;

  // ****************************************
  // Checks
  // ****************************************
  idle_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ19
    state_reg == S_IDLE |-> o_scl_oe_n && o_sda_oe_n)
    else $error("Bus not released while idle");
  data_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ5
    (state_reg == S_HIGH && $past(state_reg) == S_HIGH) |-> $stable(o_sda_oe_n))
    else $error("SDA moved while SCL high in a data bit");
  start_form_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
    $rose(state_reg == S_START) |-> o_scl_oe_n && !o_sda_oe_n && $past(o_sda_oe_n))
    else $error("Start condition malformed");
  high_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ11
    ($rose(o_scl_oe_n) && state_reg == S_HIGH) |-> ##HALF_M1_I o_scl_oe_n ##1 !o_scl_oe_n)
    else $error("SCL high half has wrong length");
  nack_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ10
    $rose(nack_reg) |-> ##[1:STOP_WIN] (state_reg == S_STOP_B && !o_sda_oe_n && o_scl_oe_n))
    else $error("No stop after a missing acknowledge");
  addr_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ12
    $rose(state_reg == S_START) |->
      shift_reg == {addr_reg, (phase_reg == P_ADDR_R)})
    else $error("Address byte layout wrong");
  ack_slot_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ8
    bit_reg <= `ISM_ACK_IDX)
    else $error("More than nine clocks in a byte");
  last_nak_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ18
    (state_reg == S_HIGH && phase_reg == P_RDATA && bit_reg == `ISM_ACK_IDX)
      |-> o_sda_oe_n == last)
    else $error("Read acknowledge wrong for byte position");
  rstart_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ16
    $rose(state_reg == S_RST_A) |-> rd_reg && phase_reg == P_ADDR_R && $past(phase_reg) == P_REG)
    else $error("Repeated start out of order");
  no_stretch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ17
    (state_reg == S_HIGH && tick) |=> state_reg != S_HIGH && !o_scl_oe_n)
    else $error("Clock waited on the slave");

endmodule

`default_nettype wire

// ==== ism_slave_model.sv ====
`default_nettype none

// ****************************************
// Addressed slave with a register file
// ****************************************
module ism_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack_data,
  output logic o_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] b;
  int n_start = 0;
  int seen = 0;
  int mack_n = 0;

  // Never drives until addressed; only pulls low or releases
  initial o_sda_oe_n = 1'b1;

  // Shift in one byte on rising clock edges, MSB first
  task automatic get_byte();
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_scl) b[i] = i_sda;
    end
  endtask

  // Answer in the ninth clock, then let go
  task automatic ack(input logic nak);
    @(negedge i_scl) o_sda_oe_n = nak;
    @(negedge i_scl) o_sda_oe_n = 1'b1;
  endtask

  // Start restarts the transfer, stop abandons it
  always @(i_sda) begin
    #1;
    if (i_scl === 1'b1) begin
      disable xfer;
      o_sda_oe_n = 1'b1;
      if (i_sda === 1'b0) n_start++;
    end
  end

  // One transaction; data changes only after the clock falls
  always begin : xfer
    wait (n_start != seen);
    seen = n_start;
    get_byte();
    if (b[7:1] == ADDR) begin
      ack(1'b0);
      if (b[0]) begin
        forever begin
          b = mem[ptr];
          ptr++;
          for (int i = 7; i >= 0; i--) begin
            o_sda_oe_n = b[i];
            @(negedge i_scl);
          end
          o_sda_oe_n = 1'b1;
          @(posedge i_scl);
          if (i_sda) wait (n_start != seen);
          mack_n++;
          @(negedge i_scl);
        end
      end else begin
        get_byte();
        ptr = b;
        ack(1'b0);
        forever begin
          get_byte();
          mem[ptr] = b;
          ptr++;
          ack(i_nack_data);
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== ism_master_tb_top.sv ====
`default_nettype none

// ****************************************
// Bench for the serial bus master
// ****************************************
module ism_master_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  logic clk, rst_n, go, rd, hold, nack_data;
  logic [6:0] addr;
  logic [7:0] regnum, len, tx_data, rx_data;
  logic tx_take, rx_valid, busy, done, nack, stretch;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, slv_oe_n, scl_q, sda_q;
  logic [7:0] wdat [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h77};
  logic [7:0] rxq [$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises = 0;
  int hi_chg = 0;
  int takes = 0;
  int per = 1000;
  int min_per = 1000;
  int d0, d1;
  // Open-drain wires with pull-ups
  wire logic scl = (scl_oe_n ? 1'b1 : scl_out) & ~hold;
  wire logic sda = (sda_oe_n ? 1'b1 : sda_out) & slv_oe_n;

  ism_master dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_rd(rd), .i_addr(addr),
    .i_regnum(regnum), .i_len(len), .i_tx_data(tx_data), .o_tx_take(tx_take),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_busy(busy), .o_done(done),
    .o_nack(nack), .o_scl_stretch(stretch), .i_scl_in(scl), .o_scl_out(scl_out),
    .o_scl_oe_n(scl_oe_n), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n)
  );
  ism_slave_model partner_u (
    .i_scl(scl), .i_sda(sda), .i_nack_data(nack_data), .o_sda_oe_n(slv_oe_n)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Bus monitor on settled levels, write data feed, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scl_q <= scl;
    sda_q <= sda;
    per <= per + 1;
    if (scl && !scl_q) begin
      rises <= rises + 1;
      per <= 1;
      if (per < min_per) min_per <= per;
    end
    if (scl && scl_q && sda !== sda_q) hi_chg <= hi_chg + 1;
    if (tx_take) takes <= takes + 1;
    if (tx_take) tx_data <= #1 wdat[takes + 1];
    if (rx_valid) rxq.push_back(rx_data);
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command, waited on up to a bounded count
  task automatic run(input logic r, input logic [6:0] a, input logic [7:0] n,
                     output int dur);
    int t0;
    @(posedge clk) #1;
    rises = 0;
    hi_chg = 0;
    takes = 0;
    rxq.delete();
    go = 1'b1;
    rd = r;
    addr = a;
    regnum = 8'h10;
    len = n;
    tx_data = wdat[0];
    t0 = cyc;
    @(posedge clk) #1;
    go = 1'b0;
    for (int i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk) #1;
    dur = cyc - t0;
    check(done, 1'b1);
    repeat (2) @(posedge clk) #1;
    check({scl, sda, busy}, 3'h6);
  endtask

  task automatic t_reset();
    check({scl_oe_n, sda_oe_n, busy, nack}, 4'hc);
    $display("test reset done");
  endtask

  task automatic t_write();
    run(1'b0, 7'h2a, 8'h03, d0);
    check(partner_u.mem[8'h10], 8'ha5);
    check(partner_u.mem[8'h12], 8'h0f);
    check(takes, 3);
    check(rises, 46);
    check(hi_chg, 2);
    check(min_per, 26);
    check(nack, 1'b0);
    check(stretch, 1'b0);
    $display("test write done");
  endtask

  task automatic t_read();
    run(1'b1, 7'h2a, 8'h03, d0);
    check(rxq.size(), 3);
    for (int i = 0; i < 3; i++) check(rxq[i], wdat[i]);
    check(partner_u.mack_n, 2);
    check(rises, 56);
    check(hi_chg, 3);
    $display("test read done");
  endtask

  task automatic t_badaddr();
    run(1'b0, 7'h15, 8'h01, d0);
    check(nack, 1'b1);
    check(rises, 10);
    check(partner_u.mem[8'h10], 8'ha5);
    $display("test bad address done");
  endtask

  task automatic t_datanack();
    nack_data = 1'b1;
    run(1'b0, 7'h2a, 8'h03, d0);
    nack_data = 1'b0;
    check(nack, 1'b1);
    check(rises, 28);
    $display("test data refusal done");
  endtask

  // Slave holds the clock low across a falling edge
  task automatic t_stretch();
    run(1'b0, 7'h2a, 8'h01, d0);
    fork
      run(1'b0, 7'h2a, 8'h01, d1);
      begin
        wait (rises == 12);
        repeat (6) @(posedge clk);
        #1 hold = 1'b1;
        repeat (14) @(posedge clk);
        #1 hold = 1'b0;
      end
    join
    check(d1, d0);
    check(stretch, 1'b1);
    $display("test stretch done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, go, rd, hold, nack_data} = 5'h0;
    addr = 7'h00;
    regnum = 8'h00;
    len = 8'h00;
    tx_data = 8'h00;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_badaddr();
    t_datanack();
    t_stretch();
    final_report();
  end
endmodule

`default_nettype wire
